// ==== core/aoc_corr_if.sv ====
// Interface between the offset configuration register and the offset router
`timescale 1ns/1ps
interface aoc_corr_if;
	import aoc_pkg::*;

	aoc_sel_t                    offset_sel;
	aoc_pair_t                   axis_pair;
	logic signed [AOC_OFS_W-1:0] first_offset;
	logic signed [AOC_OFS_W-1:0] second_offset;
	aoc_axis_t                   add_x;
	aoc_axis_t                   add_y;
	aoc_axis_t                   add_z;

	modport ctrl (
		output offset_sel,
		output axis_pair,
		output first_offset,
		output second_offset,
		input  add_x,
		input  add_y,
		input  add_z
	);

	modport router (
		input  offset_sel,
		input  axis_pair,
		input  first_offset,
		input  second_offset,
		output add_x,
		output add_y,
		output add_z
	);

endinterface

// ==== core/aoc_offset_corr.sv ====
// Offset configuration, axis correction and angle/magnitude result registers
`timescale 1ns/1ps

module aoc_offset_corr (
	// Clock and reset
	input  wire logic                                sys_clk,
	input  wire logic                                resetn,
	// Register access
	input  wire logic [aoc_pkg::AOC_ADDR_W-1:0]      reg_addr,
	input  wire logic                                reg_wr,
	input  wire logic [aoc_pkg::AOC_DATA_W-1:0]      reg_wdata,
	input  wire logic                                reg_rd,
	output logic      [aoc_pkg::AOC_DATA_W-1:0]      reg_rdata,
	output logic                                     reg_rvalid,
	// Axis pair chosen for angle calculation
	input  wire logic [1:0]                          angle_en,
	// Raw axis results
	input  wire logic                                axis_valid,
	input  wire aoc_pkg::aoc_axis_t                  axis_x,
	input  wire aoc_pkg::aoc_axis_t                  axis_y,
	input  wire aoc_pkg::aoc_axis_t                  axis_z,
	// Corrected axes towards the angle engine
	output logic                                     corr_valid,
	output aoc_pkg::aoc_axis_t                       corr_x,
	output aoc_pkg::aoc_axis_t                       corr_y,
	output aoc_pkg::aoc_axis_t                       corr_z,
	// Angle engine results
	input  wire logic                                cordic_valid,
	input  wire logic [aoc_pkg::AOC_ANGLE_W-1:0]     cordic_angle,
	input  wire logic [aoc_pkg::AOC_DATA_W-1:0]      cordic_magnitude
);
	import aoc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Saturating signed add so a large offset cannot wrap the axis
	function automatic aoc_axis_t aoc_sat_add(input aoc_axis_t a, input aoc_axis_t b);
		logic signed [AOC_DATA_W:0] sum;
		sum = {a[AOC_DATA_W-1], a} + {b[AOC_DATA_W-1], b};
		if (sum[AOC_DATA_W] != sum[AOC_DATA_W-1])
			return sum[AOC_DATA_W] ? {1'b1, {(AOC_DATA_W-1){1'b0}}}
			                       : {1'b0, {(AOC_DATA_W-1){1'b1}}};
		return sum[AOC_DATA_W-1:0];
	endfunction

	// Exact word address match, shared by write and read decode
	function automatic logic aoc_addr_hit(
		input logic [AOC_ADDR_W-1:0] addr,
		input logic [AOC_ADDR_W-1:0] target
	);
		return addr == target;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [AOC_DATA_W-1:0]  axis_offset_correction_config;
	logic [AOC_ANGLE_W-1:0] angle_value;
	logic [AOC_DATA_W-1:0]  vector_magnitude_output;
	logic [AOC_DATA_W-1:0]  angle_output;
	logic [AOC_DATA_W-1:0]  next_rdata;
	logic                   hit_cfg;
	logic                   hit_angle;
	logic                   hit_magn;
	aoc_sel_t               cfg_sel;
	logic [AOC_OFS_W-1:0]   cfg_first;
	logic [AOC_OFS_W-1:0]   cfg_second;
	aoc_axis_t              next_corr_x;
	aoc_axis_t              next_corr_y;
	aoc_axis_t              next_corr_z;

	aoc_corr_if corr_bus ();

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Unmapped addresses hit nothing: writes drop, reads give zero
	assign hit_cfg   = aoc_addr_hit(reg_addr, AOC_ADDR_OFS_CFG);
	assign hit_angle = aoc_addr_hit(reg_addr, AOC_ADDR_ANGLE);
	assign hit_magn  = aoc_addr_hit(reg_addr, AOC_ADDR_MAGN);

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Result registers have no write path, so host writes there are lost
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			axis_offset_correction_config <= AOC_RST_OFS_CFG;
		end else if (reg_wr && hit_cfg) begin
			axis_offset_correction_config <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Field extraction towards the router
	// ----------------------------------------
	assign cfg_sel    =
		aoc_sel_t'(axis_offset_correction_config[AOC_SEL_MSB:AOC_SEL_LSB]);
	assign cfg_first  =
		axis_offset_correction_config[AOC_FIRST_MSB:AOC_FIRST_LSB];
	assign cfg_second =
		axis_offset_correction_config[AOC_SECOND_MSB:AOC_SECOND_LSB];

	assign corr_bus.offset_sel    = cfg_sel;
	assign corr_bus.first_offset  = cfg_first;
	assign corr_bus.second_offset = cfg_second;
	assign corr_bus.axis_pair     = aoc_pair_t'(angle_en);

	aoc_offset_router u_router (
		.rt (corr_bus.router)
	);

	// ----------------------------------------
	// Axis correction
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			corr_valid <= 1'b0;
		end else begin
			corr_valid <= axis_valid;
		end
	end

	// Sum saturates at full scale instead of wrapping
	always_comb begin
		next_corr_x = aoc_sat_add(axis_x, corr_bus.add_x);
		next_corr_y = aoc_sat_add(axis_y, corr_bus.add_y);
		next_corr_z = aoc_sat_add(axis_z, corr_bus.add_z);
	end

	// Each corrected axis holds until the next raw sample
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			corr_x <= '0;
		end else if (axis_valid) begin
			corr_x <= next_corr_x;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			corr_y <= '0;
		end else if (axis_valid) begin
			corr_y <= next_corr_y;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			corr_z <= '0;
		end else if (axis_valid) begin
			corr_z <= next_corr_z;
		end
	end

	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			angle_value <= AOC_RST_ANGLE[AOC_ANGLE_W-1:0];
		end else if (cordic_valid) begin
			angle_value <= cordic_angle;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			vector_magnitude_output <= AOC_RST_MAGN;
		end else if (cordic_valid) begin
			vector_magnitude_output <= cordic_magnitude;
		end
	end

	// Upper bits above the 13-bit angle read as zero
	assign angle_output = {{(AOC_DATA_W-AOC_ANGLE_W){1'b0}}, angle_value};

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		if (hit_cfg) begin
			next_rdata = axis_offset_correction_config;
		end else if (hit_angle) begin
			next_rdata = angle_output;
		end else if (hit_magn) begin
			next_rdata = vector_magnitude_output;
		end else begin
			next_rdata = AOC_UNMAPPED_READ;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// Read data holds its last value between reads
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

// ==== core/aoc_offset_router.sv ====
// Steers the two scaled offsets onto the axes of the selected pair
`timescale 1ns/1ps
module aoc_offset_router (
	aoc_corr_if.router rt
);
	import aoc_pkg::*;

	// ----------------------------------------
	// Offset scaling
	// ----------------------------------------
	// Offset code is the low bits of an 11-bit code in the axis range
	function automatic aoc_axis_t aoc_scale(input logic signed [AOC_OFS_W-1:0] ofs);
		aoc_axis_t wide;
		wide = aoc_axis_t'(ofs);
		return wide <<< AOC_OFS_SHIFT;
	endfunction

	logic use_first;
	logic use_second;
	aoc_axis_t scaled_first;
	aoc_axis_t scaled_second;

	assign use_first     = (rt.offset_sel == AOC_SEL_FIRST) ||
	                       (rt.offset_sel == AOC_SEL_BOTH);
	assign use_second    = (rt.offset_sel == AOC_SEL_SECOND) ||
	                       (rt.offset_sel == AOC_SEL_BOTH);
	assign scaled_first  = aoc_scale(rt.first_offset);
	assign scaled_second = aoc_scale(rt.second_offset);

	// ----------------------------------------
	// Axis mapping
	// ----------------------------------------
	always_comb begin
		rt.add_x = '0;
		rt.add_y = '0;
		rt.add_z = '0;
		case (rt.axis_pair)
			AOC_PAIR_XY: begin
				if (use_first)
					rt.add_x = scaled_first;
				if (use_second)
					rt.add_y = scaled_second;
			end
			AOC_PAIR_YZ: begin
				if (use_first)
					rt.add_y = scaled_first;
				if (use_second)
					rt.add_z = scaled_second;
			end
			AOC_PAIR_XZ: begin
				if (use_first)
					rt.add_x = scaled_first;
				if (use_second)
					rt.add_z = scaled_second;
			end
			default: begin
				// Angle engine off: no axis is corrected
				rt.add_x = '0;
			end
		endcase
	end

endmodule

// ==== core/aoc_pkg.sv ====
// Shared constants and types for the angle offset correction block
package aoc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int          AOC_ADDR_W        = 8;
	localparam int          AOC_DATA_W        = 16;
	localparam logic [7:0]  AOC_ADDR_OFS_CFG  = 8'h12;
	localparam logic [7:0]  AOC_ADDR_ANGLE    = 8'h13;
	localparam logic [7:0]  AOC_ADDR_MAGN     = 8'h14;
	localparam logic [15:0] AOC_RST_OFS_CFG   = 16'h0000;
	localparam logic [15:0] AOC_RST_ANGLE     = 16'h0000;
	localparam logic [15:0] AOC_RST_MAGN      = 16'h0000;
	localparam logic [15:0] AOC_UNMAPPED_READ = 16'h0000;

	// ----------------------------------------
	// Field layout of the offset configuration
	// ----------------------------------------
	localparam int AOC_SEL_MSB    = 15;
	localparam int AOC_SEL_LSB    = 14;
	localparam int AOC_FIRST_MSB  = 13;
	localparam int AOC_FIRST_LSB  = 7;
	localparam int AOC_SECOND_MSB = 6;
	localparam int AOC_SECOND_LSB = 0;
	localparam int AOC_OFS_W      = 7;

	// ----------------------------------------
	// Result layout and scaling
	// ----------------------------------------
	localparam int AOC_ANGLE_W    = 13;
	localparam int AOC_ANGLE_FRAC = 4;
	localparam int AOC_CODE_W     = 11;
	localparam int AOC_OFS_SHIFT  = AOC_DATA_W - AOC_CODE_W;

	// ----------------------------------------
	// Modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		AOC_SEL_NONE   = 2'h0,
		AOC_SEL_FIRST  = 2'h1,
		AOC_SEL_SECOND = 2'h2,
		AOC_SEL_BOTH   = 2'h3
	} aoc_sel_t;

	typedef enum logic [1:0] {
		AOC_PAIR_OFF = 2'h0,
		AOC_PAIR_XY  = 2'h1,
		AOC_PAIR_YZ  = 2'h2,
		AOC_PAIR_XZ  = 2'h3
	} aoc_pair_t;

	typedef logic signed [AOC_DATA_W-1:0] aoc_axis_t;

endpackage

// ==== dv/aoc_host_model.sv ====
// Host controller model driving the register strobe port
`timescale 1ns/1ps
module aoc_host_model (
	// Clock
	input  logic        sys_clk,
	// Register access
	output logic [7:0]  reg_addr,
	output logic        reg_wr,
	output logic [15:0] reg_wdata,
	output logic        reg_rd,
	input  logic [15:0] reg_rdata,
	input  logic        reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
	end
	// Released lines show inverted values
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		ok = 1'b0;
		d = 16'h0000;
		for (int n = 0; n < 4 && !ok; n++) begin
			#1;
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
			end else @(posedge sys_clk);
		end
	endtask
endmodule

// ==== dv/aoc_offset_corr_properties.sv ====
// Port-level checker for the angle offset correction block
`timescale 1ns/1ps
module aoc_offset_corr_chk
	import aoc_pkg::*;
(
	// Clock and reset
	input logic               sys_clk,
	input logic               resetn,
	// Register access
	input logic [7:0]         reg_addr,
	input logic               reg_wr,
	input logic [15:0]        reg_wdata,
	input logic               reg_rd,
	input logic [15:0]        reg_rdata,
	input logic               reg_rvalid,
	// Axis path
	input logic [1:0]         angle_en,
	input logic               axis_valid,
	input aoc_pkg::aoc_axis_t axis_x,
	input logic               corr_valid,
	input aoc_pkg::aoc_axis_t corr_x,
	// Angle engine
	input logic               cordic_valid,
	input logic [12:0]        cordic_angle
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Shadow copies of config and angle
	// ----------------------------------------
	logic [15:0] cfg;
	logic [12:0] ang;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) cfg <= 16'h0000;
		else if (reg_wr && reg_addr == AOC_ADDR_OFS_CFG) cfg <= reg_wdata;
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) ang <= 13'h0000;
		else if (cordic_valid) ang <= cordic_angle;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_RD_LAT: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	AST_RD_IDLE: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
		else $error("read data moved without a read");
	AST_CFG_RB: assert property (reg_rd && reg_addr == AOC_ADDR_OFS_CFG
		|=> reg_rdata == $past(cfg))
		else $error("config readback wrong");
	AST_ANG_RB: assert property (reg_rd && reg_addr == AOC_ADDR_ANGLE
		|=> reg_rdata == {3'h0, $past(ang)})
		else $error("angle readback wrong");
	AST_CORR_LAT: assert property (axis_valid |=> corr_valid)
		else $error("corrected sample late");
	AST_CORR_HOLD: assert property (!axis_valid |=> !corr_valid && $stable(corr_x))
		else $error("corrected axis moved without sample");
	AST_SEL_NONE: assert property (axis_valid && cfg[15:14] == 2'h0
		|=> corr_x == $past(axis_x))
		else $error("offset applied with select off");
	AST_PAIR_OFF: assert property (axis_valid && angle_en == 2'h0 |=> corr_x == $past(axis_x))
		else $error("offset applied with pair off");
	AST_PAIR_YZ: assert property (axis_valid && angle_en == 2'h2 |=> corr_x == $past(axis_x))
		else $error("X corrected in Y-Z pair");
endmodule

bind aoc_offset_corr aoc_offset_corr_chk u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .angle_en(angle_en),
	.axis_valid(axis_valid), .axis_x(axis_x), .corr_valid(corr_valid), .corr_x(corr_x),
	.cordic_valid(cordic_valid), .cordic_angle(cordic_angle));

// ==== dv/test_angle_offset_correction_results.sv ====
// Testbench for the angle offset correction block
`timescale 1ns/1ps
module test_angle_offset_correction_results;
	import aoc_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr;
	logic reg_wr, reg_rd, reg_rvalid, corr_valid;
	logic [15:0] reg_wdata, reg_rdata, cordic_magnitude = 16'h0000;
	logic [1:0] angle_en = 2'h0;
	logic axis_valid = 1'b0;
	logic cordic_valid = 1'b0;
	logic [12:0] cordic_angle = 13'h0000;
	aoc_axis_t axis_x = 16'h0100, axis_y = 16'h0100, axis_z = 16'h0100;
	aoc_axis_t corr_x, corr_y, corr_z;
	int err_count = 0;
	int cmp_count = 0;
	always #2 sys_clk = ~sys_clk;

	aoc_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	aoc_offset_corr u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .angle_en(angle_en), .axis_valid(axis_valid),
		.axis_x(axis_x), .axis_y(axis_y), .axis_z(axis_z), .corr_valid(corr_valid),
		.corr_x(corr_x), .corr_y(corr_y), .corr_z(corr_z), .cordic_valid(cordic_valid),
		.cordic_angle(cordic_angle), .cordic_magnitude(cordic_magnitude));

	task print_verdict;
		$display("compares=%0d mismatches=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task rdc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			err_count++;
			print_verdict;
		end else begin
			chk(d, e);
		end
	endtask

	initial begin
		logic [15:0] ex, ey, ez;
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		rdc(AOC_ADDR_OFS_CFG, 16'h0000);
		u_host.wr(AOC_ADDR_ANGLE, 16'hffff);
		u_host.wr(AOC_ADDR_MAGN, 16'hffff);
		rdc(AOC_ADDR_ANGLE, 16'h0000);
		rdc(AOC_ADDR_MAGN, 16'h0000);
		rdc(8'h20, AOC_UNMAPPED_READ);
		@(posedge sys_clk);
		cordic_valid <= 1'b1;
		cordic_angle <= 13'h167f;
		cordic_magnitude <= 16'h8a5c;
		@(posedge sys_clk);
		cordic_valid <= 1'b0;
		rdc(AOC_ADDR_ANGLE, 16'h167f);
		rdc(AOC_ADDR_MAGN, 16'h8a5c);
		for (int s = 0; s < 4; s++) begin
			u_host.wr(AOC_ADDR_OFS_CFG, {s[1:0], 7'h02, 7'h7d});
			rdc(AOC_ADDR_OFS_CFG, {s[1:0], 7'h02, 7'h7d});
			for (int p = 0; p < 4; p++) begin
				ex = 16'h0100 + ((s[0] && p[0]) ? 16'h0040 : 16'h0000);
				ey = 16'h0100 + ((s[0] && p == 2) ? 16'h0040 : 16'h0000)
					+ ((s[1] && p == 1) ? 16'hffa0 : 16'h0000);
				ez = 16'h0100 + ((s[1] && p[1]) ? 16'hffa0 : 16'h0000);
				@(posedge sys_clk);
				angle_en <= p[1:0];
				axis_valid <= 1'b1;
				@(posedge sys_clk);
				axis_valid <= 1'b0;
				#1;
				chk(corr_x, ex);
				chk(corr_y, ey);
				chk(corr_z, ez);
			end
		end
		print_verdict;
	end
endmodule
